// [hpc_regs.vh]
/*
 * register offsets, field positions, reset values and timing counts
 * of the hibernation power controller.
 * assumes inclusion by bare name from the controller's design files.
 */
`ifndef HPC_REGS_VH
`define HPC_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define HPC_OFS_COUNT     9'h000
`define HPC_OFS_MATCH0    9'h004
`define HPC_OFS_MATCH1    9'h008
`define HPC_OFS_LOAD      9'h00C
`define HPC_OFS_CTL       9'h010
`define HPC_OFS_MASK      9'h014
`define HPC_OFS_STAT      9'h018
`define HPC_OFS_CLR       9'h01C
`define HPC_OFS_TRIM      9'h020
`define HPC_MEM_BASE_BIT  8

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define HPC_CTL_SLEEP_REQ 0
`define HPC_CTL_CLK_EN    1
`define HPC_CTL_CLK_SEL   2
`define HPC_CTL_RTC_EN    3
`define HPC_CTL_LB_EN     4
`define HPC_CTL_LB_ABORT  5
`define HPC_CTL_IO_RETAIN 6
`define HPC_CTL_RTC_WAKE  7
`define HPC_CTL_PIN_WAKE  8
`define HPC_CTL_STORED_HI 8
`define HPC_CTL_LOW_BAT   30
`define HPC_CTL_WC        31

// ---------------------------------------------------------------
// status and mask fields
// ---------------------------------------------------------------
`define HPC_ST_MATCH0     0
`define HPC_ST_MATCH1     1
`define HPC_ST_WAKE       2
`define HPC_ST_LOW_BAT    3
`define HPC_ST_W          4

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define HPC_TRIM_RST      16'h7FFF
`define HPC_NOMINAL_DIV   16'h7FFF
`define HPC_TRIM_PERIOD   6'h3F
`define HPC_XTAL_DIV      128
`define HPC_WR_SETTLE     4'h3

`endif

// [hpc_mem.v]
/*
 * battery-backed word store of the hibernation power controller.
 * assumes a single clock; read data appear from a register one
 * cycle after the read strobe.
 */
`default_nettype none

module hpc_mem #(
  parameter WORDS  = 64,
  parameter AW     = 6,
  parameter DW     = 32
) (
  input  wire          clk_in,
  input  wire          wr_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  input  wire          rd_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out
);

  reg [DW-1:0] store [0:WORDS-1];

  // write port and registered read port
  always @(posedge clk_in) begin
    if (wr_in) begin
      store[wr_addr_in] <= wr_data_in;
    end
    if (rd_in) begin
      rd_data_out <= store[rd_addr_in];
    end
  end

endmodule

`default_nettype wire

// [hpc_rtc.v]
/*
 * seconds counter with trimmed predivider.
 * assumes tick_in is a one-cycle pulse at the 32.768-kHz reference.
 */
`default_nettype none
`include "hpc_regs.vh"

module hpc_rtc #(
  parameter CW = 32
) (
  input  wire          clk_in,
  input  wire          rst_in,
  input  wire          tick_in,
  input  wire          run_in,
  input  wire          load_in,
  input  wire [CW-1:0] load_value_in,
  input  wire [15:0]   trim_in,
  output reg  [CW-1:0] count_out,
  output reg           second_out
);

  reg [15:0] prediv;
  reg [5:0]  sec_phase;

  // predivider reload: trim once in 64 seconds, nominal otherwise
  wire [15:0] reload = (sec_phase == `HPC_TRIM_PERIOD) ? trim_in
                                                       : `HPC_NOMINAL_DIV;

  // ---------------------------------------------------------------
  // count down reference ticks, step seconds
  // ---------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prediv     <= `HPC_NOMINAL_DIV;
      sec_phase  <= 6'h00;
      count_out  <= {CW{1'b0}};
      second_out <= 1'b0;
    end else begin
      second_out <= 1'b0;
      if (load_in) begin
        count_out <= load_value_in;
        prediv    <= reload;
      end else if (run_in && tick_in) begin
        if (prediv == 16'h0000) begin
          prediv     <= reload;
          sec_phase  <= sec_phase + 6'h01;
          count_out  <= count_out + {{(CW-1){1'b0}}, 1'b1};
          second_out <= 1'b1;
        end else begin
          prediv <= prediv - 16'h0001;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [hpc_top.v]
/*
 * hibernation power controller: power-off request pin, io-retain
 * switch control, wake logic, seconds counter with two matches,
 * low-battery watch, event flags and battery-backed words.
 * assumes a synchronous register port (read data one cycle later)
 * and that the slow oscillator pin is synchronous to clk_in.
 */
// Our own choices: the strobed register port and the register offsets.
`default_nettype none
`include "hpc_regs.vh"

module hpc_top #(
  parameter CW       = 32,
  parameter WORDS    = 64,
  parameter XTAL_DIV = `HPC_XTAL_DIV
) (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire [8:0]  addr_in,
  input  wire [31:0] wr_data_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output wire [31:0] rd_data_out,
  input  wire        wake_n_in,
  input  wire        low_battery_in,
  input  wire        low_freq_osc_in,
  output reg         low_freq_osc_out,
  output wire        power_off_request_n_out,
  output reg         power_off_request_n_oe_out,
  output reg         core_power_off_out,
  output reg         hibernating_out,
  output wire        irq_out
);

  // ---------------------------------------------------------------
  // states and decode helpers
  // ---------------------------------------------------------------
  localparam ST_RUN = 1'b0;
  localparam ST_HIB = 1'b1;

  // battery-backed words sit above the register block
  function is_mem;
    input [8:0] a;
    begin
      is_mem = a[`HPC_MEM_BASE_BIT];
    end
  endfunction

  reg         state;
  reg         next_state;
  reg         pend;
  reg [3:0]   pend_cnt;
  reg [8:0]   pend_addr;
  reg [31:0]  pend_data;
  reg [`HPC_CTL_STORED_HI:1] ctl;
  reg [CW-1:0] match0;
  reg [CW-1:0] match1;
  reg [15:0]  trim;
  reg [`HPC_ST_W-1:0] stat;
  reg [`HPC_ST_W-1:0] mask;
  reg [31:0]  rd_reg;
  reg         rd_was_mem;
  reg         osc_d;
  reg [6:0]   xtal_cnt;
  reg         slow_tick;
  reg         second_seen;

  wire [CW-1:0] count;
  wire          second_pulse;
  wire [31:0]   mem_q;

  // ---------------------------------------------------------------
  // delayed write commit (models crossing into the slow domain)
  // ---------------------------------------------------------------
  wire commit   = pend && (pend_cnt == 4'h0);
  wire c_ctl    = commit && (pend_addr == `HPC_OFS_CTL);
  wire c_load   = commit && (pend_addr == `HPC_OFS_LOAD);
  wire c_clr    = commit && (pend_addr == `HPC_OFS_CLR);
  wire c_mem    = commit && is_mem(pend_addr);

  // a new write is taken only while no earlier one is pending
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend      <= 1'b0;
      pend_cnt  <= 4'h0;
      pend_addr <= 9'h000;
      pend_data <= 32'h0000_0000;
    end else if (!pend && wr_in) begin
      pend      <= 1'b1;
      pend_cnt  <= `HPC_WR_SETTLE;
      pend_addr <= addr_in;
      pend_data <= wr_data_in;
    end else if (commit) begin
      pend      <= 1'b0;
    end else if (pend) begin
      pend_cnt  <= pend_cnt - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  wire slow_en    = ctl[`HPC_CTL_CLK_EN];
  wire slow_sel   = ctl[`HPC_CTL_CLK_SEL];
  wire rtc_en     = ctl[`HPC_CTL_RTC_EN];
  wire lb_en      = ctl[`HPC_CTL_LB_EN];
  wire lb_abort   = ctl[`HPC_CTL_LB_ABORT];
  wire io_retain  = ctl[`HPC_CTL_IO_RETAIN];
  wire rtc_wake   = ctl[`HPC_CTL_RTC_WAKE];
  wire pin_wake   = ctl[`HPC_CTL_PIN_WAKE];

  // stored on commit of the held write
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl    <= {`HPC_CTL_STORED_HI{1'b0}};
      match0 <= {CW{1'b0}};
      match1 <= {CW{1'b0}};
      trim   <= `HPC_TRIM_RST;
      mask   <= {`HPC_ST_W{1'b0}};
    end else if (commit) begin
      case (pend_addr)
        `HPC_OFS_CTL:    ctl    <= pend_data[`HPC_CTL_STORED_HI:1];
        `HPC_OFS_MATCH0: match0 <= pend_data[CW-1:0];
        `HPC_OFS_MATCH1: match1 <= pend_data[CW-1:0];
        `HPC_OFS_TRIM:   trim   <= pend_data[15:0];
        `HPC_OFS_MASK:   mask   <= pend_data[`HPC_ST_W-1:0];
        default:         mask   <= mask;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // slow reference: crystal divided or oscillator direct
  // ---------------------------------------------------------------
  wire osc_rise = low_freq_osc_in && !osc_d;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_d            <= 1'b0;
      xtal_cnt         <= 7'h00;
      slow_tick        <= 1'b0;
      low_freq_osc_out <= 1'b0;
    end else begin
      osc_d     <= low_freq_osc_in;
      slow_tick <= 1'b0;
      // crystal feedback only while the crystal source runs
      low_freq_osc_out <= slow_en && !slow_sel &&
                          !low_freq_osc_in;
      if (!slow_en) begin
        xtal_cnt <= 7'h00;
      end else if (osc_rise) begin
        if (slow_sel) begin
          slow_tick <= 1'b1;
        end else if (xtal_cnt == XTAL_DIV[6:0] - 7'h01) begin
          xtal_cnt  <= 7'h00;
          slow_tick <= 1'b1;
        end else begin
          xtal_cnt  <= xtal_cnt + 7'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // seconds counter
  // ---------------------------------------------------------------
  hpc_rtc #(
    .CW            (CW)
  ) u_rtc (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .tick_in       (slow_tick),
    .run_in        (rtc_en),
    .load_in       (c_load),
    .load_value_in (pend_data[CW-1:0]),
    .trim_in       (trim),
    .count_out     (count),
    .second_out    (second_pulse)
  );

  // compare one cycle after each new second
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      second_seen <= 1'b0;
    end else begin
      second_seen <= second_pulse;
    end
  end

  wire hit0 = second_seen && (count == match0);
  wire hit1 = second_seen && (count == match1);

  // ---------------------------------------------------------------
  // sleep sequencing
  // ---------------------------------------------------------------
  wire sleep_req = c_ctl && pend_data[`HPC_CTL_SLEEP_REQ];
  wire lb_seen   = lb_en && low_battery_in && (state == ST_RUN);
  // the request's own write carries enable and abort, so setting
  // them together with the request already blocks it
  wire lb_block  = pend_data[`HPC_CTL_LB_EN] &&
                   pend_data[`HPC_CTL_LB_ABORT] &&
                   low_battery_in;
  wire pin_ev    = pin_wake && !wake_n_in;
  wire rtc_ev    = rtc_wake && (hit0 || hit1);

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (sleep_req && !lb_block) begin
          next_state = ST_HIB;
        end
      end
      ST_HIB: begin
        if (pin_ev || rtc_ev) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  // power pin and internal switch outputs
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state                      <= ST_RUN;
      power_off_request_n_oe_out <= 1'b0;
      core_power_off_out         <= 1'b0;
      hibernating_out            <= 1'b0;
    end else begin
      state           <= next_state;
      hibernating_out <= (next_state == ST_HIB);
      // external regulator path unless io power is retained
      power_off_request_n_oe_out <= (next_state == ST_HIB) &&
                                    !io_retain;
      core_power_off_out         <= (next_state == ST_HIB) &&
                                    io_retain;
    end
  end

  // open-drain: only ever pulls low
  assign power_off_request_n_out = 1'b0;

  // ---------------------------------------------------------------
  // event flags: hardware set wins over software clear
  // ---------------------------------------------------------------
  wire [`HPC_ST_W-1:0] ev_set;
  assign ev_set[`HPC_ST_MATCH0]  = hit0;
  assign ev_set[`HPC_ST_MATCH1]  = hit1;
  assign ev_set[`HPC_ST_WAKE]    = (state == ST_HIB) && pin_ev;
  assign ev_set[`HPC_ST_LOW_BAT] = lb_seen;

  wire [`HPC_ST_W-1:0] ev_clr = c_clr ? pend_data[`HPC_ST_W-1:0]
                                      : {`HPC_ST_W{1'b0}};

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat <= {`HPC_ST_W{1'b0}};
    end else begin
      stat <= (stat & ~ev_clr) | ev_set;
    end
  end

  assign irq_out = |(stat & mask);

  // ---------------------------------------------------------------
  // battery-backed words
  // ---------------------------------------------------------------
  hpc_mem #(
    .WORDS       (WORDS),
    .AW          (6),
    .DW          (32)
  ) u_mem (
    .clk_in      (clk_in),
    .wr_in       (c_mem),
    .wr_addr_in  (pend_addr[7:2]),
    .wr_data_in  (pend_data),
    .rd_in       (rd_in && is_mem(addr_in)),
    .rd_addr_in  (addr_in[7:2]),
    .rd_data_out (mem_q)
  );

  // ---------------------------------------------------------------
  // read port: every read answered the next cycle
  // ---------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_reg     <= 32'h0000_0000;
      rd_was_mem <= 1'b0;
    end else if (rd_in) begin
      rd_was_mem <= is_mem(addr_in);
      case (addr_in)
        `HPC_OFS_COUNT:  rd_reg <= count;
        `HPC_OFS_MATCH0: rd_reg <= match0;
        `HPC_OFS_MATCH1: rd_reg <= match1;
        `HPC_OFS_CTL: begin
          rd_reg <= 32'h0000_0000;
          rd_reg[`HPC_CTL_STORED_HI:1]  <= ctl;
          rd_reg[`HPC_CTL_SLEEP_REQ]    <= state;
          rd_reg[`HPC_CTL_LOW_BAT]      <= lb_en && low_battery_in;
          rd_reg[`HPC_CTL_WC]           <= !pend;
        end
        `HPC_OFS_MASK:
          rd_reg <= {{(32-`HPC_ST_W){1'b0}}, mask};
        `HPC_OFS_STAT:
          rd_reg <= {{(32-`HPC_ST_W){1'b0}}, stat};
        `HPC_OFS_TRIM:   rd_reg <= {16'h0000, trim};
        default:         rd_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign rd_data_out = rd_was_mem ? mem_q : rd_reg;

endmodule

`default_nettype wire

// [hpc_top_monitor.sv]
/*
 * checker for the hibernation power controller top ports.
 * assumes bind from the bench top; one clock, async reset.
 */
`default_nettype none
`include "hpc_regs.vh"

module hpc_top_monitor #(
  parameter CW       = 32,
  parameter WORDS    = 64,
  parameter XTAL_DIV = 128
) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [8:0]  addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rd_data_out,
  input wire logic        wake_n_in,
  input wire logic        low_battery_in,
  input wire logic        low_freq_osc_in,
  input wire logic        low_freq_osc_out,
  input wire logic        power_off_request_n_out,
  input wire logic        power_off_request_n_oe_out,
  input wire logic        core_power_off_out,
  input wire logic        hibernating_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic wr_seen;
  logic pin_en;
  logic lb_block;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // shadow of control bits as software wrote them
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_seen  <= 1'b0;
      pin_en   <= 1'b0;
      lb_block <= 1'b0;
    end else if (wr_in) begin
      wr_seen <= 1'b1;
      if (addr_in == `HPC_OFS_CTL) begin
        pin_en   <= wr_data_in[`HPC_CTL_PIN_WAKE];
        lb_block <= wr_data_in[`HPC_CTL_LB_EN] &
                    wr_data_in[`HPC_CTL_LB_ABORT];
      end
    end
  end

  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  sequence s_wr_then_ctl_rd;
    wr_in ##2 (rd_in && addr_in == `HPC_OFS_CTL);
  endsequence
  sequence s_pin_wake;
    hibernating_out && pin_en && !wake_n_in;
  endsequence

  property p_od_data;
    power_off_request_n_out == 1'b0;
  endproperty
  property p_oe_rise;
    $rose(power_off_request_n_oe_out) |-> ##[0:1] hibernating_out;
  endproperty
  property p_wake_pin;
    s_pin_wake |-> ##[1:4] !hibernating_out;
  endproperty
  property p_block;
    lb_block && low_battery_in && $past(low_battery_in)
      |-> !$rose(hibernating_out);
  endproperty
  property p_release;
    $fell(hibernating_out) |-> ##[0:1]
      (!power_off_request_n_oe_out && !core_power_off_out);
  endproperty
  property p_core_only;
    core_power_off_out |-> !power_off_request_n_oe_out;
  endproperty
  property p_wc_clr;
    s_wr_then_ctl_rd |=> !rd_data_out[`HPC_CTL_WC];
  endproperty
  property p_wc_rst;
    rd_in && addr_in == `HPC_OFS_CTL && !wr_seen
      |=> rd_data_out[`HPC_CTL_WC];
  endproperty
  property p_trim_rst;
    rd_in && addr_in == `HPC_OFS_TRIM && !wr_seen
      |=> rd_data_out == 32'h00007FFF;
  endproperty

  a_od_data: assert property (p_od_data)
    else $error("power-off pin data not low");
  a_oe_rise: assert property (p_oe_rise)
    else $error("power-off pin driven outside sleep");
  a_wake_pin: assert property (p_wake_pin)
    else $error("wake pin did not end sleep");
  a_block: assert property (p_block)
    else $error("sleep entered on low battery");
  a_release: assert property (p_release)
    else $error("power not restored on wake");
  a_core_only: assert property (p_core_only)
    else $error("both power mechanisms active");
  a_wc_clr: assert property (p_wc_clr)
    else $error("write complete not cleared");
  a_wc_rst: assert property (p_wc_rst)
    else $error("write complete low after reset");
  a_trim_rst: assert property (p_trim_rst)
    else $error("trim reset value wrong");
endmodule

`default_nettype wire

// [hpc_far_side.sv]
/*
 * far-side model: slow oscillator, wake source, regulator.
 * assumes the oscillator is synchronous to the main clock.
 */
`default_nettype none

module hpc_far_side (
  input  wire logic clk_in,
  input  wire logic wake_req_in,
  input  wire logic pin_oe_in,
  output var  logic osc_out,
  output var  logic wake_n_out,
  output wire logic supply_on_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial osc_out = 1'b0;
  initial wake_n_out = 1'b1;

  // free-running slow clock, independent of the bus
  always @(posedge clk_in) osc_out <= ~osc_out;

  // wake switch, active low
  always @(posedge clk_in) wake_n_out <= ~wake_req_in;

  // pull-up: released pin keeps the regulator on
  assign supply_on_out = ~pin_oe_in;
endmodule

`default_nettype wire

// [tb_hibernation_power_control.sv]
/*
 * self-checking bench for the hibernation power controller.
 * assumes the far-side model and the checker file are compiled.
 */
`default_nettype none
`include "hpc_regs.vh"

module tb_hibernation_power_control;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_in, rst_in, wr, rd, low_bat, wake_req;
  logic [8:0]  addr;
  logic [31:0] wdata, v, v2;
  wire  [31:0] rdata;
  wire         osc, osc_fb, wake_n, od, oe, core_off, power_off_request_n, irq, sup;
  int          error_cnt, checked, cyc, n, t;

  hpc_top DUT (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
    .rd_data_out(rdata), .wake_n_in(wake_n),
    .low_battery_in(low_bat), .low_freq_osc_in(osc),
    .low_freq_osc_out(osc_fb), .power_off_request_n_out(od),
    .power_off_request_n_oe_out(oe), .core_power_off_out(core_off),
    .hibernating_out(power_off_request_n), .irq_out(irq)
  );

  hpc_far_side u_far (
    .clk_in(clk_in), .wake_req_in(wake_req), .pin_oe_in(oe),
    .osc_out(osc), .wake_n_out(wake_n), .supply_on_out(sup)
  );

  // ---------------------------------------------------------------
  // bus tasks and compare
  // ---------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr    <= 1'b0;
  endtask
  task automatic rd2(input logic [8:0] a, b, output logic [31:0] d, e);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    addr <= b;
    #1;
    d = rdata;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    e = rdata;
  endtask
  task automatic wr_ok(input logic [8:0] a, input logic [31:0] d);
    wr_reg(a, d);
    n = 0;
    do begin
      rd2(`HPC_OFS_CTL, `HPC_OFS_CTL, v, v2);
      n++;
    end while (v2[31] !== 1'b1 && n < 20);
    cmp("write complete", 32'h1, {31'h0, v2[31]});
  endtask
  task automatic wait_hib(input logic lvl, input int lim);
    for (int i = 0; i < lim && power_off_request_n !== lvl; i++) @(posedge clk_in);
    #1;
    cmp("hibernating", {31'h0, lvl}, {31'h0, power_off_request_n});
  endtask
  task automatic fb_toggles(output int c);
    logic p;
    c = 0;
    p = osc_fb;
    repeat (16) begin
      @(posedge clk_in);
      #1;
      if (osc_fb !== p) c++;
      p = osc_fb;
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // clock and hang guard
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_in);
      cyc++;
      if (cyc == 90000) begin
        error_cnt++;
        final_report;
      end
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    rst_in = 1'b1; wr = 1'b0; rd = 1'b0; addr = 9'h000;
    wdata = 32'h0; low_bat = 1'b0; wake_req = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    rd2(`HPC_OFS_CTL, `HPC_OFS_TRIM, v, v2);
    cmp("ctl wc", 32'h1, {31'h0, v[31]});
    cmp("trim", 32'h00007FFF, v2);
    cmp("supply", 32'h1, {31'h0, sup});
    wr_reg(`HPC_OFS_MATCH1, 32'hA5C30F1E);
    // match register is not read back until the write has landed
    rd2(`HPC_OFS_CTL, `HPC_OFS_CTL, v, v2);
    cmp("wc pending", 32'h0, {31'h0, v[31]});
    wr_ok(`HPC_OFS_CTL, 32'h0);
    rd2(`HPC_OFS_MATCH1, 9'h040, v, v2);
    cmp("match1", 32'hA5C30F1E, v);
    cmp("unmapped", 32'h0, v2);
    wr_ok(9'h1FC, 32'h12345678);
    rd2(9'h1FC, 9'h1FC, v, v2);
    cmp("last word", 32'h12345678, v2);
    fb_toggles(t);
    cmp("fb off", 32'h0, t);
    // crystal start-up: no register access until it has settled
    wr_reg(`HPC_OFS_CTL, 32'h00000002);
    repeat (64) @(posedge clk_in);
    rd2(`HPC_OFS_CTL, `HPC_OFS_CTL, v, v2);
    cmp("wc after start", 32'h1, {31'h0, v[31]});
    fb_toggles(t);
    cmp("fb crystal", 32'h10, t);
    wr_ok(`HPC_OFS_CTL, 32'h0000000E);
    fb_toggles(t);
    cmp("fb oscillator", 32'h0, t);
    // pin wake with the external regulator
    wr_ok(`HPC_OFS_MASK, 32'h00000004);
    wr_ok(`HPC_OFS_CTL, 32'h0000010F);
    wait_hib(1'b1, 8);
    cmp("supply off", 32'h0, {31'h0, sup});
    cmp("core off", 32'h0, {31'h0, core_off});
    wake_req <= 1'b1;
    wait_hib(1'b0, 8);
    wake_req <= 1'b0;
    cmp("supply back", 32'h1, {31'h0, sup});
    cmp("irq wake", 32'h1, {31'h0, irq});
    wr_ok(`HPC_OFS_CLR, 32'h00000004);
    cmp("irq clear", 32'h0, {31'h0, irq});
    // io-retain sleep
    wr_ok(`HPC_OFS_CTL, 32'h0000014F);
    wait_hib(1'b1, 8);
    cmp("core cut", 32'h1, {31'h0, core_off});
    cmp("io supply", 32'h1, {31'h0, sup});
    wake_req <= 1'b1;
    wait_hib(1'b0, 8);
    wake_req <= 1'b0;
    cmp("core back", 32'h0, {31'h0, core_off});
    // low battery refuses sleep; enable and abort ride on the request
    @(posedge clk_in);
    low_bat <= 1'b1;
    wr_ok(`HPC_OFS_CTL, 32'h0000003F);
    repeat (4) @(posedge clk_in);
    #1;
    cmp("no sleep", 32'h0, {31'h0, power_off_request_n});
    rd2(`HPC_OFS_CTL, `HPC_OFS_STAT, v, v2);
    cmp("low bat now", 32'h1, {31'h0, v[30]});
    cmp("low bat flag", 32'h1, {31'h0, v2[3]});
    @(posedge clk_in);
    low_bat <= 1'b0;
    // counter match wake
    wr_ok(`HPC_OFS_LOAD, 32'h00000010);
    wr_ok(`HPC_OFS_MATCH0, 32'h00000011);
    wr_ok(`HPC_OFS_CTL, 32'h0000008F);
    wait_hib(1'b1, 8);
    wait_hib(1'b0, 70000);
    rd2(`HPC_OFS_COUNT, `HPC_OFS_STAT, v, v2);
    cmp("count", 32'h00000011, v);
    cmp("match0 flag", 32'h1, {31'h0, v2[0]});
    final_report;
  end
endmodule

bind hpc_top hpc_top_monitor #(
  .CW(CW), .WORDS(WORDS), .XTAL_DIV(XTAL_DIV)
) u_mon (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
  .rd_data_out(rd_data_out), .wake_n_in(wake_n_in),
  .low_battery_in(low_battery_in), .low_freq_osc_in(low_freq_osc_in),
  .low_freq_osc_out(low_freq_osc_out),
  .power_off_request_n_out(power_off_request_n_out),
  .power_off_request_n_oe_out(power_off_request_n_oe_out),
  .core_power_off_out(core_power_off_out),
  .hibernating_out(hibernating_out), .irq_out(irq_out)
);

`default_nettype wire
